// >>> hw/cbx_cfg.svh
`ifndef CBX_CFG_SVH
`define CBX_CFG_SVH

// High-byte opcodes of the four conditional branches.
`define CBX_OP_CSET 8'he2
`define CBX_OP_NSET 8'he6
`define CBX_OP_CCLR 8'he3
`define CBX_OP_NCLR 8'he7
// High nibble of the bit-clear instruction.
`define CBX_OP_BITCLR 4'h9

// Instruction word field positions.
`define CBX_IW_W 16
`define CBX_HI_MSB 15
`define CBX_HI_LSB 8
`define CBX_NIB_LSB 12
`define CBX_BIT_MSB 11
`define CBX_BIT_LSB 9
`define CBX_A_POS 8
`define CBX_LIT_W 8

// Data memory addressing.
`define CBX_DADDR_W 12
`define CBX_BANK_W 4
`define CBX_ILO_MAX 8'h5f
`define CBX_ACC_SPLIT 8'h60
`define CBX_ACC_LO_BANK 4'h0
`define CBX_ACC_HI_BANK 4'hf

// Program counter advance past a single-word instruction, in bytes.
`define CBX_PC_STEP 2
// Last index of the four idle cycles after a taken branch.
`define CBX_NOP_LAST 2'h3
// Single-bit mask seed for the bit-clear operation.
`define CBX_BIT_ONE 8'h01

`endif

// >>> hw/cbx_pkg.sv
package cbx_pkg;

   // Instructions that this block executes; everything else is foreign.
   typedef enum logic [2:0] {
      OP_NONE,
      OP_CSET,
      OP_NSET,
      OP_CCLR,
      OP_NCLR,
      OP_BITCLR
   } cbx_op_e;

   // One state for each quarter of the instruction cycle, plus the
   // four dead cycles that follow a taken branch.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_Q1,
      ST_Q2,
      ST_Q3,
      ST_Q4,
      ST_NOP
   } cbx_st_e;

endpackage : cbx_pkg

// >>> hw/cbx_addr_if.sv
`timescale 1ns/1ps
`include "cbx_cfg.svh"

// Operand fields going to the address resolver and its answer back.
interface cbx_addr_if;
   logic [`CBX_LIT_W-1:0] f;
   logic a;
   logic [`CBX_BANK_W-1:0] bank;
   logic ext_en;
   logic [`CBX_DADDR_W-1:0] fsr2;
   logic [`CBX_DADDR_W-1:0] addr;
   logic ilo;

   modport requester(output f, a, bank, ext_en, fsr2, input addr, ilo);
   modport resolver(input f, a, bank, ext_en, fsr2, output addr, ilo);
endinterface : cbx_addr_if

// >>> hw/cbx_addr_res.sv
`timescale 1ns/1ps
`include "cbx_cfg.svh"

module cbx_addr_res import cbx_pkg::*; (
   cbx_addr_if.resolver bus // Operand fields in, data address out.
);

   // Pure decode so the address is ready within the decode quarter.
   // The split of the access bank into low RAM and high special
   // registers is fixed here and shared by every byte instruction.
   always_comb begin
      bus.ilo = 1'h0;
      if (bus.a) begin
         bus.addr = {bus.bank, bus.f};
      end else if (bus.ext_en && (bus.f <= `CBX_ILO_MAX)) begin
         // Indexed literal offset: the literal is added to the pointer.
         bus.ilo = 1'h1;
         bus.addr = bus.fsr2 + {{(`CBX_DADDR_W-`CBX_LIT_W){1'h0}}, bus.f};
      end else if (bus.f < `CBX_ACC_SPLIT) begin
         bus.addr = {`CBX_ACC_LO_BANK, bus.f};
      end else begin
         bus.addr = {`CBX_ACC_HI_BANK, bus.f};
      end
   end

endmodule : cbx_addr_res

// >>> hw/cbx_exec.sv
`timescale 1ns/1ps
`include "cbx_cfg.svh"

module cbx_exec import cbx_pkg::*; #(
   parameter int PC_W = 21 // Program counter width in bits.
) (
   input wire logic clk_i, // Core clock, 20 MHz.
   input wire logic rst_i, // Asynchronous reset, active high.
   input wire logic instr_valid_i, // Instruction word offered.
   input wire logic [`CBX_IW_W-1:0] instr_i, // Instruction word.
   input wire logic [PC_W-1:0] instr_addr_i, // Address of that word.
   output logic instr_ready_o, // Word is taken this cycle.
   input wire logic carry_i, // Carry flag.
   input wire logic negative_i, // Negative flag.
   input wire logic ext_set_en_i, // Extended instruction set on.
   input wire logic [`CBX_BANK_W-1:0] bank_sel_i, // Bank register.
   input wire logic [`CBX_DADDR_W-1:0] fsr2_i, // Index pointer.
   output logic pc_wr_o, // Program counter load strobe.
   output logic [PC_W-1:0] pc_o, // Program counter load value.
   output logic dmem_rd_o, // Data memory read strobe.
   output logic dmem_wr_o, // Data memory write strobe.
   output logic [`CBX_DADDR_W-1:0] dmem_addr_o, // Data address.
   input wire logic [`CBX_LIT_W-1:0] dmem_rdata_i, // Read data.
   output logic [`CBX_LIT_W-1:0] dmem_wdata_o, // Write data.
   output logic indexed_o, // Operand came from indexed mode.
   output logic status_wr_o, // Status flag write, never raised.
   output logic done_o, // Last cycle of the instruction.
   output logic unsupported_o // Finished word was not ours.
);

   cbx_st_e st_q, st_d;
   cbx_op_e op_q, op_d;
   logic [`CBX_IW_W-1:0] ir_q, ir_d;
   logic [PC_W-1:0] ia_q, ia_d;
   logic take_q, take_d;
   logic [1:0] cnt_q, cnt_d;
   logic [`CBX_LIT_W-1:0] rdat_q, rdat_d;
   logic [`CBX_LIT_W-1:0] wdat_q, wdat_d;
   logic [`CBX_DADDR_W-1:0] addr_q, addr_d;
   logic ilo_q, ilo_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic pcwr_q, pcwr_d;
   logic rd_q, rd_d;
   logic wr_q, wr_d;
   logic accept;
   logic [PC_W-1:0] br_disp;
   logic [PC_W-1:0] br_tgt;
   logic [`CBX_LIT_W-1:0] clr_mask;

   // Opcode decode, shared by the accept path and the checks below.
   function automatic cbx_op_e decode_op(
      input logic [`CBX_IW_W-1:0] iw
   );
      cbx_op_e op;
      op = OP_NONE;
      if (iw[`CBX_HI_MSB:`CBX_NIB_LSB] == `CBX_OP_BITCLR) begin
         op = OP_BITCLR;
      end else if (iw[`CBX_HI_MSB:`CBX_HI_LSB] == `CBX_OP_CSET) begin
         op = OP_CSET;
      end else if (iw[`CBX_HI_MSB:`CBX_HI_LSB] == `CBX_OP_NSET) begin
         op = OP_NSET;
      end else if (iw[`CBX_HI_MSB:`CBX_HI_LSB] == `CBX_OP_CCLR) begin
         op = OP_CCLR;
      end else if (iw[`CBX_HI_MSB:`CBX_HI_LSB] == `CBX_OP_NCLR) begin
         op = OP_NCLR;
      end
      return op;
   endfunction : decode_op

   // Branch test against the flag level seen in the process quarter.
   function automatic logic branch_taken(
      input cbx_op_e op,
      input logic c,
      input logic n
   );
      logic t;
      t = 1'h0;
      unique case (op)
         OP_CSET: t = c;
         OP_NSET: t = n;
         OP_CCLR: t = !c;
         OP_NCLR: t = !n;
         OP_BITCLR, OP_NONE: t = 1'h0;
      endcase
      return t;
   endfunction : branch_taken

   // The operand address is resolved from the live bank and pointer
   // during the decode quarter and then held for the whole cycle.
   cbx_addr_if aif();

   assign aif.f = ir_q[`CBX_LIT_W-1:0];
   assign aif.a = ir_q[`CBX_A_POS];
   assign aif.bank = bank_sel_i;
   assign aif.ext_en = ext_set_en_i;
   assign aif.fsr2 = fsr2_i;

   cbx_addr_res u_addr_res (
      .bus(aif.resolver)
   );

   // Doubled, sign-extended offset; bit 0 of the offset is always zero.
   assign br_disp = {{(PC_W-`CBX_LIT_W-1){ir_q[`CBX_LIT_W-1]}},
                     ir_q[`CBX_LIT_W-1:0], 1'h0};
   // The base is the branch address plus one word, since the counter
   // has already moved on by the time the branch is seen.
   assign br_tgt = ia_q + PC_W'(`CBX_PC_STEP) + br_disp;
   assign clr_mask = ~(`CBX_BIT_ONE << ir_q[`CBX_BIT_MSB:`CBX_BIT_LSB]);

   // Handshake: a new word may enter in the last cycle of the previous
   // one, so instructions can follow back to back with no gap.
   assign done_o = ((st_q == ST_Q4) && !take_q) ||
                   ((st_q == ST_NOP) && (cnt_q == `CBX_NOP_LAST));
   assign instr_ready_o = (st_q == ST_IDLE) || done_o;
   assign accept = instr_valid_i && instr_ready_o;
   assign unsupported_o = done_o && (op_q == OP_NONE);

   // Neither the branches nor the bit clear touch the flags.
   assign status_wr_o = 1'h0;

   // Next-state logic for the four quarters and the four dead cycles.
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      ir_d = ir_q;
      ia_d = ia_q;
      take_d = take_q;
      cnt_d = cnt_q;
      rdat_d = rdat_q;
      wdat_d = wdat_q;
      addr_d = addr_q;
      ilo_d = ilo_q;
      pc_d = pc_q;
      pcwr_d = 1'h0;
      rd_d = 1'h0;
      wr_d = 1'h0;
      unique case (st_q)
         ST_IDLE: begin
            st_d = ST_IDLE;
         end
         ST_Q1: begin
            // Decode quarter: latch the operand address.
            st_d = ST_Q2;
            addr_d = aif.addr;
            ilo_d = aif.ilo;
            rd_d = (op_q == OP_BITCLR);
         end
         ST_Q2: begin
            // Read quarter: capture the target register.
            st_d = ST_Q3;
            if (op_q == OP_BITCLR) begin
               rdat_d = dmem_rdata_i;
            end
         end
         ST_Q3: begin
            // Process quarter: decide the branch, build the result.
            st_d = ST_Q4;
            take_d = branch_taken(op_q, carry_i, negative_i);
            if (take_d) begin
               pc_d = br_tgt;
               pcwr_d = 1'h1;
            end
            if (op_q == OP_BITCLR) begin
               wdat_d = rdat_q & clr_mask;
               wr_d = 1'h1;
            end
         end
         ST_Q4: begin
            // A taken branch flushes the prefetched word with a NOP.
            if (take_q) begin
               st_d = ST_NOP;
               cnt_d = 2'h0;
            end else begin
               st_d = ST_IDLE;
            end
         end
         ST_NOP: begin
            cnt_d = cnt_q + 2'h1;
            if (cnt_q == `CBX_NOP_LAST) begin
               st_d = ST_IDLE;
            end
         end
      endcase
      if (accept) begin
         st_d = ST_Q1;
         ir_d = instr_i;
         ia_d = instr_addr_i;
         op_d = decode_op(instr_i);
         take_d = 1'h0;
      end
   end

   // State registers only; all decisions are made above.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= ST_IDLE;
         op_q <= OP_NONE;
         ir_q <= '0;
         ia_q <= '0;
         take_q <= 1'h0;
         cnt_q <= 2'h0;
         rdat_q <= '0;
         wdat_q <= '0;
         addr_q <= '0;
         ilo_q <= 1'h0;
         pc_q <= '0;
         pcwr_q <= 1'h0;
         rd_q <= 1'h0;
         wr_q <= 1'h0;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         ir_q <= ir_d;
         ia_q <= ia_d;
         take_q <= take_d;
         cnt_q <= cnt_d;
         rdat_q <= rdat_d;
         wdat_q <= wdat_d;
         addr_q <= addr_d;
         ilo_q <= ilo_d;
         pc_q <= pc_d;
         pcwr_q <= pcwr_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
      end
   end

   // Data outputs straight from their flops.
   assign pc_o = pc_q;
   assign pc_wr_o = pcwr_q;
   assign dmem_rd_o = rd_q;
   assign dmem_wr_o = wr_q;
   assign dmem_addr_o = addr_q;
   assign dmem_wdata_o = wdat_q;
   assign indexed_o = ilo_q;

   // Checks on the executed behaviour.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_cset_taken;
      (st_q == ST_Q3) && (decode_op(ir_q) == OP_CSET) && carry_i
         |=> pc_wr_o && (st_q == ST_Q4);
   endproperty
   a_cset_taken: assert property (p_cset_taken)
      else $error("Branch on carry set did not load the counter.");

   property p_nset_taken;
      (st_q == ST_Q3) && (op_q == OP_NSET)
         |=> (pc_wr_o == $past(negative_i));
   endproperty
   a_nset_taken: assert property (p_nset_taken)
      else $error("Branch on negative set ignored the flag.");

   property p_cclr_hold;
      (st_q == ST_Q3) && (op_q == OP_CCLR) && carry_i
         |=> !pc_wr_o ##1 (st_q != ST_NOP);
   endproperty
   a_cclr_hold: assert property (p_cclr_hold)
      else $error("Branch on carry clear taken with carry set.");

   property p_nclr_taken;
      (st_q == ST_Q3) && (op_q == OP_NCLR) && !negative_i |=> pc_wr_o;
   endproperty
   a_nclr_taken: assert property (p_nclr_taken)
      else $error("Branch on negative clear not taken.");

   property p_target;
      pc_wr_o |-> (pc_o == ia_q + PC_W'(`CBX_PC_STEP) +
                  (PC_W'(signed'(ir_q[`CBX_LIT_W-1:0])) << 1));
   endproperty
   a_target: assert property (p_target)
      else $error("Branch target is not address plus two plus 2n.");

   sequence s_dead_cycle;
      (st_q == ST_NOP) && !pc_wr_o && !dmem_wr_o && !dmem_rd_o;
   endsequence

   property p_taken_len;
      pc_wr_o |=> s_dead_cycle [*4] ##1 (st_q != ST_NOP);
   endproperty
   a_taken_len: assert property (p_taken_len)
      else $error("Taken branch did not add exactly four dead cycles.");

   property p_not_taken;
      (st_q == ST_Q3) && (op_q inside {OP_CSET, OP_NSET, OP_CCLR, OP_NCLR})
         && !branch_taken(op_q, carry_i, negative_i)
         |=> !pc_wr_o && done_o && $stable(pc_o);
   endproperty
   a_not_taken: assert property (p_not_taken)
      else $error("Untaken branch wrote the counter or ran long.");

   property p_branch_no_mem;
      (op_q != OP_BITCLR) |-> !dmem_wr_o && !dmem_rd_o && !status_wr_o;
   endproperty
   a_branch_no_mem: assert property (p_branch_no_mem)
      else $error("A branch touched data memory or the flags.");

   property p_clear_bit;
      (st_q == ST_Q2) && (op_q == OP_BITCLR)
         |-> ##2 dmem_wr_o && (dmem_wdata_o == ($past(dmem_rdata_i, 2)
            & ~(`CBX_BIT_ONE << ir_q[`CBX_BIT_MSB:`CBX_BIT_LSB])));
   endproperty
   a_clear_bit: assert property (p_clear_bit)
      else $error("Bit clear wrote the wrong value.");

   property p_bank_sel;
      (st_q == ST_Q2) && (op_q == OP_BITCLR) && ir_q[`CBX_A_POS]
         |-> (dmem_addr_o == {$past(bank_sel_i), ir_q[`CBX_LIT_W-1:0]});
   endproperty
   a_bank_sel: assert property (p_bank_sel)
      else $error("Bank register not used for the operand.");

   property p_indexed;
      (st_q == ST_Q2) && (op_q == OP_BITCLR) && !ir_q[`CBX_A_POS]
         && $past(ext_set_en_i)
         && (ir_q[`CBX_LIT_W-1:0] <= `CBX_ILO_MAX)
         |-> indexed_o && (dmem_addr_o == $past(fsr2_i)
            + `CBX_DADDR_W'(ir_q[`CBX_LIT_W-1:0]));
   endproperty
   a_indexed: assert property (p_indexed)
      else $error("Indexed literal offset not applied.");

   sequence s_rmw;
      dmem_rd_o ##1 (!dmem_rd_o && !dmem_wr_o) ##1
         (dmem_wr_o && done_o);
   endsequence

   property p_rmw;
      (st_q == ST_Q1) && (op_q == OP_BITCLR) |=> s_rmw;
   endproperty
   a_rmw: assert property (p_rmw)
      else $error("Bit clear did not read, modify and write in order.");

endmodule : cbx_exec

// >>> test/cbx_dmem_model.sv
`timescale 1ns/1ps

// Byte-wide data memory answering the bit-clear port.
module cbx_dmem_model (
   input wire logic clk_i, // Core clock.
   input wire logic rd_i, // Read strobe.
   input wire logic wr_i, // Write strobe.
   input wire logic [11:0] addr_i, // Byte address.
   input wire logic [7:0] wdata_i, // Write data.
   output logic [7:0] rdata_o // Read data.
);
   logic [7:0] mem [0:4095];
   logic [7:0] junk;

   // Preset contents follow a formula that the bench repeats.
   initial begin
      junk = 8'h5a;
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i * 59 + 21);
      end
   end

   // The bus churns outside a read, so a late sample is never plausible.
   always @(posedge clk_i) begin
      junk <= ~junk + 8'h01;
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   // A read is answered within its own strobe cycle.
   assign rdata_o = rd_i ? mem[addr_i] : junk;
endmodule : cbx_dmem_model

// >>> test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   logic clk = 1'b0;
   logic rst, instr_valid, instr_ready, carry, negative, ext_set_en;
   logic [15:0] instr;
   logic [20:0] instr_addr, pc;
   logic [3:0] bank_sel;
   logic [11:0] fsr2, dmem_addr;
   logic pc_wr, dmem_rd, dmem_wr, indexed, status_wr, done, unsupported;
   logic [7:0] dmem_rdata, dmem_wdata;
   logic [31:0] seed = 32'h4722;
   logic [7:0] ops [4] = '{8'he2, 8'he6, 8'he3, 8'he7};
   int mismatches = 0;
   int checks = 0;
   int ref_mem [int];

   cbx_exec #(.PC_W(21)) cbx_exec_i (
      .clk_i(clk), .rst_i(rst), .instr_valid_i(instr_valid),
      .instr_i(instr), .instr_addr_i(instr_addr),
      .instr_ready_o(instr_ready), .carry_i(carry),
      .negative_i(negative), .ext_set_en_i(ext_set_en),
      .bank_sel_i(bank_sel), .fsr2_i(fsr2), .pc_wr_o(pc_wr), .pc_o(pc),
      .dmem_rd_o(dmem_rd), .dmem_wr_o(dmem_wr), .dmem_addr_o(dmem_addr),
      .dmem_rdata_i(dmem_rdata), .dmem_wdata_o(dmem_wdata),
      .indexed_o(indexed), .status_wr_o(status_wr), .done_o(done),
      .unsupported_o(unsupported));

   cbx_dmem_model cbx_dmem_model_i (
      .clk_i(clk), .rd_i(dmem_rd), .wr_i(dmem_wr), .addr_i(dmem_addr),
      .wdata_i(dmem_wdata), .rdata_o(dmem_rdata));

   // Free-running core clock, 50 ns period.
   always #25 clk = ~clk;

   // Xorshift source; a fixed start keeps every run the same.
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // Memory as the bench believes it to be after its own writes.
   function automatic int ref_rd(int a);
      return ref_mem.exists(a) ? ref_mem[a] : (a * 59 + 21) & 255;
   endfunction : ref_rd

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   // Issues one word from idle, watches each cycle, then compares.
   task automatic run(input logic [15:0] iw, input logic [20:0] ia,
                      input logic c, input logic n, input logic ext,
                      input logic [3:0] bank, input logic [11:0] fsr);
      int kind, cyc, f, ea, pcw, rd_at, wr_at, exp_pc, exp_wd, last;
      logic take, ix, ix_seen, uns, stw;
      logic [20:0] pc_seen;
      logic [11:0] ad_seen;
      logic [7:0] wd_seen;
      kind = (iw[15:12] == 4'h9) ? 2 :
             (iw[15:9] == 7'h71 || iw[15:9] == 7'h73) ? 1 : 0;
      case (iw[15:8])
         8'he2: take = c;
         8'he6: take = n;
         8'he3: take = !c;
         8'he7: take = !n;
         default: take = 1'b0;
      endcase
      exp_pc = (int'(ia) + 2 + 2 * int'($signed(iw[7:0]))) & 32'h1fffff;
      last = (kind == 1 && take) ? 8 : 4;
      f = iw[7:0];
      ix = !iw[8] && ext && f <= 95;
      if (ix) begin
         ea = (int'(fsr) + f) & 12'hfff;
      end else if (!iw[8]) begin
         ea = (f < 96) ? f : 12'hf00 | f;
      end else begin
         ea = int'(bank) * 256 + f;
      end
      exp_wd = ref_rd(ea) & ~(1 << iw[11:9]);
      check("ready_idle", instr_ready, 1);
      instr = iw;
      instr_addr = ia;
      carry = c;
      negative = n;
      ext_set_en = ext;
      bank_sel = bank;
      fsr2 = fsr;
      instr_valid = 1'b1;
      @(posedge clk);
      #2 instr_valid = 1'b0;
      instr = ~iw;
      cyc = 0;
      pcw = 0;
      rd_at = 0;
      wr_at = 0;
      stw = 1'b0;
      uns = 1'b0;
      while (cyc < 12) begin
         @(negedge clk);
         cyc++;
         stw = stw | status_wr;
         check("ready", instr_ready, cyc == last);
         if (pc_wr === 1'b1) begin
            pcw++;
            pc_seen = pc;
         end
         if (dmem_rd === 1'b1) begin
            rd_at = cyc;
         end
         if (dmem_wr === 1'b1) begin
            wr_at = cyc;
            ad_seen = dmem_addr;
            wd_seen = dmem_wdata;
            ix_seen = indexed;
         end
         if (done === 1'b1) begin
            uns = unsupported;
            break;
         end
      end
      check("cycles", cyc, (kind == 1 && take) ? 8 : 4);
      check("pc_loads", pcw, kind == 1 && take);
      if (kind == 1 && take) begin
         check("pc_target", pc_seen, exp_pc);
      end
      check("flag_write", stw, 0);
      check("foreign", uns, kind == 0);
      check("rd_cycle", rd_at, kind == 2 ? 2 : 0);
      check("wr_cycle", wr_at, kind == 2 ? 4 : 0);
      if (kind == 2) begin
         check("addr", ad_seen, ea);
         check("indexed", ix_seen, ix);
         check("wdata", wd_seen, exp_wd);
         ref_mem[ea] = exp_wd;
      end
      @(posedge clk);
      #2;
   endtask : run

   // Hang guard, far beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_of_test();
   end

   // Reset, directed corners, then random words.
   initial begin
      logic [31:0] r, w;
      logic [15:0] iw;
      rst = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0000;
      instr_addr = 21'h000000;
      carry = 1'b0;
      negative = 1'b0;
      ext_set_en = 1'b0;
      bank_sel = 4'h0;
      fsr2 = 12'h000;
      repeat (16) @(posedge clk);
      #2 rst = 1'b0;
      @(negedge clk);
      check("done_rst", done, 0);
      check("pc_wr_rst", pc_wr, 0);
      check("ready_rst", instr_ready, 1);
      check("pc_rst", pc, 0);
      @(posedge clk);
      #2;
      // Extreme offsets, both flag values, target wrapping at the top.
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 4; k++) begin
            run({ops[i], k[1] ? 8'h80 : 8'h7f},
                k[1] ? 21'h000010 : 21'h1ffff0, k[0], k[0], 1'b0,
                4'h0, 12'h000);
         end
      end
      // Bit clear across the indexed and access-bank boundary.
      for (int k = 0; k < 8; k++) begin
         run({4'h9, k[2:0], k[0], k[1] ? 8'h60 : 8'h5f}, 21'h000100,
             1'b0, 1'b0, k[2], 4'h3, 12'hffc);
      end
      run(16'he500, 21'h000040, 1'b1, 1'b1, 1'b0, 4'h0, 12'h000);
      // Two foreign words back to back: the second enters on done.
      instr = 16'h0000;
      instr_valid = 1'b1;
      @(posedge clk);
      #2 instr = 16'h0001;
      repeat (4) @(negedge clk);
      check("b2b_ready", instr_ready, 1);
      @(posedge clk);
      #2 instr_valid = 1'b0;
      repeat (3) @(negedge clk);
      check("b2b_busy", instr_ready, 0);
      @(negedge clk);
      check("b2b_done", done, 1);
      check("b2b_foreign", unsupported, 1);
      @(posedge clk);
      #2;
      for (int k = 0; k < 80; k++) begin
         r = xs();
         w = xs();
         if (r[2:0] < 4) begin
            iw = {ops[r[1:0]], w[7:0]};
         end else if (r[2:0] < 6) begin
            iw = {4'h9, w[11:0]};
         end else begin
            iw = {4'h0, w[11:0]};
         end
         run(iw, {r[23:4], 1'b0}, r[24], r[25], r[26], r[30:27], w[27:16]);
      end
      end_of_test();
   end
endmodule : tb_top
